// ### core/tws_defines.vh
// Register map, field positions, status codes and timing for the two-wire target
`ifndef TWS_DEFINES_VH
`define TWS_DEFINES_VH
// Register byte offsets
`define TWS_OFF_CTRL    8'h00
`define TWS_OFF_STATUS  8'h04
`define TWS_OFF_ADDR    8'h08
`define TWS_OFF_DATA    8'h0c
`define TWS_OFF_IRQ_ST  8'h10
`define TWS_OFF_IRQ_MSK 8'h14
`define TWS_OFF_SLEEP   8'h18
// Control fields
`define TWS_CTL_EVENT   7
`define TWS_CTL_ACK     6
`define TWS_CTL_START   5
`define TWS_CTL_STOP    4
`define TWS_CTL_ENABLE  2
`define TWS_CTL_MASK    7'h74
// Reset values
`define TWS_RST_CTRL    8'h00
`define TWS_RST_ADDR    8'hfe
`define TWS_RST_DATA    8'hff
// Status codes
`define TWS_ST_IDLE     8'hf8
`define TWS_ST_SR_OWN   8'h60
`define TWS_ST_SR_ALOWN 8'h68
`define TWS_ST_SR_GC    8'h70
`define TWS_ST_SR_ALGC  8'h78
`define TWS_ST_SR_DACK  8'h80
`define TWS_ST_SR_DNACK 8'h88
`define TWS_ST_GC_DACK  8'h90
`define TWS_ST_GC_DNACK 8'h98
`define TWS_ST_STOP     8'ha0
`define TWS_ST_ST_OWN   8'ha8
`define TWS_ST_ST_AL    8'hb0
`define TWS_ST_ST_DACK  8'hb8
`define TWS_ST_ST_DNACK 8'hc0
`define TWS_ST_ST_LAST  8'hc8
`define TWS_GC_ADDR     7'h00
`define TWS_ALL_ONES    8'hff
// Interrupt status bits
`define TWS_IRQ_EVENT   0
`define TWS_IRQ_WAKE    1
`define TWS_IRQ_START   2
`define TWS_IRQ_W       3
// Timing
`define TWS_CLK_NS      40
`define TWS_HOLD_NS     300
`define TWS_HOLD_CYC    ((`TWS_HOLD_NS + `TWS_CLK_NS - 1) / `TWS_CLK_NS)
`endif

// ### core/tws_target.v
// Two-wire bus target with receive and transmit paths and AXI4-Lite registers
//
// Notes on behaviour
// - Own address is address register bits [7:1]; match gives a response.
// - Address register bit 0 one also accepts general call address 0x00.
// - Matched address with write bit zero enters receive, else transmit.
// - After own address and write, event flag sets with valid status code.
// - Arbitration lost then addressed for write reports 0x68 or 0x78.
// - Acknowledge enable cleared mid transfer gives not-acknowledge after next byte.
// - Acknowledge enable zero ignores own address but keeps watching the bus.
// - Sleep with acknowledge enable: match address, wake, hold clock low.
// - Data register after wake need not hold last bus byte.
// - Status 0x60 for own address write, 0x70 for general call.
// - Address states leave data register alone, wait for flag clear.
// - Flag clear receives next byte, ack per acknowledge enable written.
// - Transfer end with acknowledge enable returns to not-addressed, watching addresses.
// - Start request on release: not-addressed, then start when bus free.
// - Last byte sent with ack off, controller acks: 0xc8, send ones.
`timescale 1ns/10ps
`include "tws_defines.vh"
module tws_target #(
   parameter HOLD_CYC = `TWS_HOLD_CYC
) (
   // Clock and reset
   input  wire        aclk,
   input  wire        aresetn,
   // AXI4-Lite write
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   // AXI4-Lite read
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // Bus pins
   input  wire        scl_i,
   output wire        scl_o,
   output wire        scl_oe,
   input  wire        sda_i,
   output wire        sda_o,
   output wire        sda_oe,
   // Arbitration loss from controller path, same clock
   input  wire        arb_lost,
   // Start request towards controller path
   output reg         start_req_q,
   // Interrupt
   output wire        irq
);
   //==========================================================
   // Pin synchronisers
   reg [1:0] scl_s_q;
   reg [1:0] sda_s_q;
   reg       scl_p_q;
   reg       sda_p_q;
   always @(posedge aclk) begin
      if (!aresetn) begin
         scl_s_q <= 2'h3;
         sda_s_q <= 2'h3;
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
      end else begin
         scl_s_q <= {scl_s_q[0], scl_i};
         sda_s_q <= {sda_s_q[0], sda_i};
         scl_p_q <= scl_s_q[1];
         sda_p_q <= sda_s_q[1];
      end
   end
   wire scl = scl_s_q[1];
   wire sda = sda_s_q[1];
   wire scl_rise = scl & ~scl_p_q;
   wire scl_fall = ~scl & scl_p_q;
   wire bus_start = scl & scl_p_q & ~sda & sda_p_q;
   wire bus_stop  = scl & scl_p_q & sda & ~sda_p_q;

   //==========================================================
   // Registers
   reg [7:0] ctrl_q;
   reg [7:0] addr_q;
   reg [7:0] data_q;
   reg [7:0] status_q;
   reg [3:0] irq_st_q;
   reg [3:0] irq_msk_q;
   reg       sleep_q;
   reg       busy_q;
   wire      en_b  = ctrl_q[`TWS_CTL_ENABLE];
   wire      ack_b = ctrl_q[`TWS_CTL_ACK];
   wire      flag  = ctrl_q[`TWS_CTL_EVENT];

   // Bus slave handshake: take address and data in either order
   reg        aw_ok_q;
   reg        w_ok_q;
   reg [7:0]  aw_q;
   reg [31:0] w_q;
   reg [3:0]  ws_q;
   assign s_axi_awready = ~aw_ok_q & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_ok_q & ~s_axi_bvalid;
   assign s_axi_arready = ~s_axi_rvalid;
   wire wr_go = aw_ok_q & w_ok_q;
   wire wr_b0 = wr_go & ws_q[0];
   wire wr_ctrl = wr_b0 & (aw_q == `TWS_OFF_CTRL);
   wire flag_clr = wr_ctrl & w_q[`TWS_CTL_EVENT];

   //==========================================================
   // Target state machine
   localparam S_IDLE = 3'h0;
   localparam S_ADDR = 3'h1;
   localparam S_RACK = 3'h2;
   localparam S_RX   = 3'h3;
   localparam S_TX   = 3'h4;
   localparam S_TACK = 3'h5;
   localparam S_WAIT = 3'h6;
   localparam S_IGN  = 3'h7;
   reg [2:0] st_q;
   reg [2:0] nx_after_q;
   reg [3:0] bit_q;
   reg [7:0] sh_q;
   reg       ack_drv_q;
   reg       sda_drv_q;
   reg       hold_q;
   reg       gc_q;
   reg       rx_mode_q;
   reg       ack_sent_q;
   reg       last_q;
   reg       al_q;
   reg       ev_set;
   reg       data_q_ld_pending;
   reg [7:0] ev_code;
   reg [15:0] hold_cnt_q;
   wire own_hit = (sh_q[7:1] == addr_q[7:1]);
   wire gc_hit  = (sh_q[7:1] == `TWS_GC_ADDR) & addr_q[0];

   always @(posedge aclk) begin
      if (!aresetn) begin
         st_q       <= S_IDLE;
         nx_after_q <= S_IDLE;
         bit_q      <= 4'h0;
         sh_q       <= 8'h00;
         ack_drv_q  <= 1'b0;
         sda_drv_q  <= 1'b0;
         hold_q     <= 1'b0;
         gc_q       <= 1'b0;
         rx_mode_q  <= 1'b0;
         ack_sent_q <= 1'b0;
         last_q     <= 1'b0;
         al_q       <= 1'b0;
         ev_set     <= 1'b0;
         data_q_ld_pending <= 1'b0;
         ev_code    <= `TWS_ST_IDLE;
         hold_cnt_q <= 16'h0000;
         busy_q     <= 1'b0;
      end else begin
         ev_set <= 1'b0;
         if (arb_lost)
            al_q <= 1'b1;
         if (bus_start)
            busy_q <= 1'b1;
         else if (bus_stop)
            busy_q <= 1'b0;
         if (!en_b) begin
            st_q      <= S_IDLE;
            ack_drv_q <= 1'b0;
            sda_drv_q <= 1'b0;
            hold_q    <= 1'b0;
         end else if (bus_start) begin
            st_q      <= S_ADDR;
            bit_q     <= 4'h0;
            ack_drv_q <= 1'b0;
            sda_drv_q <= 1'b0;
         end else if (bus_stop) begin
            st_q      <= S_IDLE;
            ack_drv_q <= 1'b0;
            sda_drv_q <= 1'b0;
            hold_q    <= 1'b0;
            al_q      <= 1'b0;
         end else begin
            case (st_q)
               S_ADDR, S_RX: begin
                  if (scl_rise) begin
                     sh_q  <= {sh_q[6:0], sda};
                     bit_q <= bit_q + 4'h1;
                  end else if (scl_fall && bit_q == 4'h8) begin
                     bit_q <= 4'h0;
                     if (st_q == S_ADDR) begin
                        data_q_ld_pending <= 1'b0;
                        last_q            <= 1'b0;
                        if (ack_b && (own_hit || gc_hit)) begin
                           ack_drv_q <= 1'b1;
                           gc_q      <= gc_hit & ~own_hit;
                           rx_mode_q <= ~sh_q[0];
                           st_q      <= S_RACK;
                        end else begin
                           st_q <= S_IGN;
                        end
                     end else begin
                        data_q_ld_pending <= 1'b1;
                        ack_drv_q  <= ack_b;
                        ack_sent_q <= ack_b;
                        st_q       <= S_RACK;
                     end
                  end
               end
               S_RACK: begin
                  if (scl_fall) begin
                     ack_drv_q <= 1'b0;
                     hold_q    <= 1'b1;
                     hold_cnt_q <= 16'h0000;
                     ev_set    <= 1'b1;
                     st_q      <= S_WAIT;
                     if (bit_q == 4'h0 && !data_q_ld_pending) begin
                        if (rx_mode_q) begin
                           nx_after_q <= S_RX;
                           if (al_q)
                              ev_code <= gc_q ? `TWS_ST_SR_ALGC : `TWS_ST_SR_ALOWN;
                           else
                              ev_code <= gc_q ? `TWS_ST_SR_GC : `TWS_ST_SR_OWN;
                        end else begin
                           nx_after_q <= S_TX;
                           ev_code    <= al_q ? `TWS_ST_ST_AL : `TWS_ST_ST_OWN;
                        end
                     end else begin
                        nx_after_q <= ack_sent_q ? S_RX : S_IGN;
                        if (gc_q)
                           ev_code <= ack_sent_q ? `TWS_ST_GC_DACK : `TWS_ST_GC_DNACK;
                        else
                           ev_code <= ack_sent_q ? `TWS_ST_SR_DACK : `TWS_ST_SR_DNACK;
                     end
                  end
               end
               S_WAIT: begin
                  if (hold_cnt_q != 16'hffff)
                     hold_cnt_q <= hold_cnt_q + 16'h0001;
                  if (flag_clr && !w_q[`TWS_CTL_STOP]) begin
                     hold_q <= 1'b0;
                     bit_q  <= 4'h0;
                     st_q   <= nx_after_q;
                     if (nx_after_q == S_TX) begin
                        sh_q      <= last_q ? `TWS_ALL_ONES : data_q;
                        last_q    <= ~w_q[`TWS_CTL_ACK];
                        sda_drv_q <= ~(last_q ? 1'b1 : data_q[7]);
                     end
                  end
               end
               S_TX: begin
                  if (scl_fall) begin
                     bit_q <= bit_q + 4'h1;
                     if (bit_q == 4'h7) begin
                        sda_drv_q <= 1'b0;
                        st_q      <= S_TACK;
                     end else begin
                        sh_q      <= {sh_q[6:0], 1'b1};
                        sda_drv_q <= ~sh_q[6];
                     end
                  end
               end
               S_TACK: begin
                  if (scl_rise) begin
                     ev_set <= 1'b1;
                     hold_q <= 1'b0;
                     if (sda) begin
                        ev_code    <= `TWS_ST_ST_DNACK;
                        nx_after_q <= S_IGN;
                     end else begin
                        ev_code    <= last_q ? `TWS_ST_ST_LAST : `TWS_ST_ST_DACK;
                        nx_after_q <= last_q ? S_IGN : S_TX;
                     end
                     st_q <= S_WAIT;
                     hold_cnt_q <= 16'h0000;
                  end
               end
               S_IGN: begin
                  ack_drv_q <= 1'b0;
               end
               default: st_q <= S_IDLE;
            endcase
            if (st_q == S_WAIT && hold_q == 1'b0 && scl_fall)
               hold_q <= 1'b1;
         end
      end
   end

   //==========================================================
   // Data register capture; not done during address states
   always @(posedge aclk) begin
      if (!aresetn) begin
         data_q <= `TWS_RST_DATA;
      end else begin
         if (st_q == S_RX && scl_fall && bit_q == 4'h8)
            data_q <= sh_q;
         else if (wr_b0 && aw_q == `TWS_OFF_DATA && st_q != S_RX)
            data_q <= w_q[7:0];
      end
   end

   //==========================================================
   // Pin drive: open drain, enable pulls low
   // Clock stays low from the ack fall until software releases it
   wire hold_scl = (st_q == S_WAIT) & (hold_q | sleep_q);
   assign scl_o  = 1'b0;
   assign scl_oe = hold_scl;
   assign sda_o  = 1'b0;
   assign sda_oe = ack_drv_q | sda_drv_q;

   //==========================================================
   // Register writes, status and interrupts
   wire wake_ev = ev_set & sleep_q & ack_b;
   always @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q      <= `TWS_RST_CTRL;
         addr_q      <= `TWS_RST_ADDR;
         status_q    <= `TWS_ST_IDLE;
         irq_st_q    <= 4'h0;
         irq_msk_q   <= 4'h0;
         sleep_q     <= 1'b0;
         start_req_q <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            ctrl_q[6:0] <= w_q[6:0] & `TWS_CTL_MASK;
            if (w_q[`TWS_CTL_START] && st_q == S_WAIT && nx_after_q == S_IGN)
               start_req_q <= 1'b1;
         end
         if (wr_b0 && aw_q == `TWS_OFF_ADDR)
            addr_q <= w_q[7:0];
         if (wr_b0 && aw_q == `TWS_OFF_SLEEP)
            sleep_q <= w_q[0];
         if (wr_b0 && aw_q == `TWS_OFF_IRQ_MSK)
            irq_msk_q <= w_q[3:0];
         // Event flag: set wins over a clearing write
         if (ev_set) begin
            ctrl_q[`TWS_CTL_EVENT] <= 1'b1;
            status_q <= ev_code;
         end else if (flag_clr) begin
            ctrl_q[`TWS_CTL_EVENT] <= 1'b0;
         end
         if (wake_ev)
            sleep_q <= 1'b0;
         if (start_req_q && !busy_q)
            start_req_q <= 1'b0;
         irq_st_q <= (irq_st_q & ~((wr_b0 && aw_q == `TWS_OFF_IRQ_ST) ? w_q[3:0] : 4'h0))
                   | {(hold_cnt_q == HOLD_CYC[15:0]), start_req_q & ~busy_q,
                      wake_ev, ev_set};
      end
   end
   assign irq = |(irq_st_q & irq_msk_q);

   //==========================================================
   // AXI4-Lite channel handling
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_ok_q      <= 1'b0;
         w_ok_q       <= 1'b0;
         aw_q         <= 8'h00;
         w_q          <= 32'h0000_0000;
         ws_q         <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'h0;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp  <= 2'h0;
         s_axi_rdata  <= 32'h0000_0000;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_ok_q <= 1'b1;
            aw_q    <= {s_axi_awaddr[7:2], 2'h0};
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_ok_q <= 1'b1;
            w_q    <= s_axi_wdata;
            ws_q   <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_ok_q      <= 1'b0;
            w_ok_q       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_q > `TWS_OFF_SLEEP) ? 2'h2 : 2'h0;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= 2'h0;
            case ({s_axi_araddr[7:2], 2'h0})
               `TWS_OFF_CTRL:    s_axi_rdata <= {24'h0, ctrl_q};
               `TWS_OFF_STATUS:  s_axi_rdata <= {24'h0, status_q};
               `TWS_OFF_ADDR:    s_axi_rdata <= {24'h0, addr_q};
               `TWS_OFF_DATA:    s_axi_rdata <= {24'h0, data_q};
               `TWS_OFF_IRQ_ST:  s_axi_rdata <= {28'h0, irq_st_q};
               `TWS_OFF_IRQ_MSK: s_axi_rdata <= {28'h0, irq_msk_q};
               `TWS_OFF_SLEEP:   s_axi_rdata <= {31'h0, sleep_q};
               default: begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= 2'h2;
               end
            endcase
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule

// ### verification/tb_top.sv
// Testbench for the two-wire target
`timescale 1ns/10ps
module tb_top;
   reg         aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, arb_lost, ack;
   reg  [7:0]  awaddr, araddr, q, ra, rc, rb, re, s1, s2, dexp;
   reg  [31:0] wdata, rd;
   reg  [47:0] rows [0:6];
   reg  [1:0]  rr;
   wire        awready, wready, bvalid, arready, rvalid, irq, start_req_q;
   wire [1:0]  bresp, rresp;
   wire [31:0] rdata;
   wire        scl_o, scl_oe, sda_o, sda_oe, m_scl, m_sda, scl, sda;
   integer     miscompares, tests_run, i, n;
   assign scl = !(scl_oe || m_scl);
   assign sda = !(sda_oe || m_sda);
   tws_target #(.HOLD_CYC(2)) i_dut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o),
      .sda_oe(sda_oe), .arb_lost(arb_lost), .start_req_q(start_req_q), .irq(irq));
   tws_bus_master i_m (.aclk(aclk), .scl(scl), .sda(sda), .scl_low(m_scl), .sda_low(m_sda));
   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end
   // ==========
   // Shared tasks
   task end_of_test;
      begin
         $display("checks %0d mismatches %0d", tests_run, miscompares);
         if (miscompares == 0 && tests_run > 0)
            $display("*** PASS ***");
         else
            $display("*** FAIL ***");
         $finish;
      end
   endtask
   task chk(input [79:0] nm, input [31:0] e, input [31:0] g);
      begin
         tests_run = tests_run + 1;
         if (g !== e) begin
            miscompares = miscompares + 1;
            $display("mismatch %0s expected %h seen %h", nm, e, g);
         end
      end
   endtask
   // Ready is looked at on the falling edge, so it is the value of the next rising edge
   task axw(input [7:0] a, input [31:0] d);
      reg ta, tw;
      begin
         @(posedge aclk);
         awaddr <= a;
         wdata <= d;
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         bready <= 1'b1;
         ta = 1'b0;
         tw = 1'b0;
         while (!(ta && tw)) begin
            @(negedge aclk);
            ta = ta || awready;
            tw = tw || wready;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
         end
         @(negedge aclk);
         while (!bvalid) @(negedge aclk);
         @(posedge aclk);
         bready <= 1'b0;
      end
   endtask
   task axr(input [7:0] a);
      begin
         @(posedge aclk);
         araddr <= a;
         arvalid <= 1'b1;
         rready <= 1'b1;
         @(negedge aclk);
         while (!arready) @(negedge aclk);
         @(posedge aclk);
         arvalid <= 1'b0;
         @(negedge aclk);
         while (!rvalid) @(negedge aclk);
         rd = rdata;
         rr = rresp;
         @(posedge aclk);
         rready <= 1'b0;
      end
   endtask
   task wflag;
      begin
         n = 0;
         rd = 0;
         while (!rd[7] && n < 300) begin
            axr(8'h00);
            n = n + 1;
         end
         chk("flag", 32'h1, {31'h0, rd[7]});
      end
   endtask
   // ==========
   // Watchdog, about 75000 cycles
   initial begin
      #3000000;
      miscompares = miscompares + 1;
      end_of_test;
   end
   initial begin
      {awvalid, wvalid, bready, arvalid, rready, arb_lost} = 6'h0;
      {awaddr, araddr, wdata} = 48'h0;
      miscompares = 0;
      tests_run = 0;
      dexp = 8'hff;
      aresetn = 1'b0;
      // Own address, control, sent byte, expected ack, status after address, after data
      rows[0] = {8'h54, 8'h44, 8'h54, 8'h00, 8'h60, 8'h88};
      rows[1] = {8'h54, 8'h44, 8'h56, 8'h01, 8'h00, 8'h00};
      rows[2] = {8'h54, 8'h44, 8'h00, 8'h01, 8'h00, 8'h00};
      rows[3] = {8'h55, 8'h44, 8'h00, 8'h00, 8'h70, 8'h98};
      rows[4] = {8'h54, 8'h04, 8'h54, 8'h01, 8'h00, 8'h00};
      rows[5] = {8'h54, 8'h44, 8'h54, 8'h00, 8'h60, 8'h88};
      rows[6] = {8'h54, 8'h44, 8'h55, 8'h00, 8'ha8, 8'hc0};
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      for (i = 0; i < 8; i = i + 1) begin
         axr(i * 4);
         chk("reset", (i == 1) ? 32'hf8 : (i == 2) ? 32'hfe : (i == 3) ? 32'hff : 0, rd);
      end
      axr(8'h1c);
      chk("unmapped", 32'h2, {30'h0, rr});
      for (i = 0; i < 7; i = i + 1) begin
         {ra, rc, rb, re, s1, s2} = rows[i];
         axw(8'h08, {24'h0, ra});
         axw(8'h00, {24'h0, rc});
         i_m.start;
         i_m.xfer(rb, q, ack);
         chk("addr_ack", {24'h0, re}, {31'h0, ack});
         if (!re[0]) begin
            wflag;
            axr(8'h04);
            chk("status", {24'h0, s1}, rd);
            axr(8'h0c);
            chk("data_keep", {24'h0, dexp}, rd);
            axw(8'h00, 32'h84);
            i_m.xfer(rb[0] ? 8'hff : 8'h30 + i[7:0], q, ack);
            chk("data_nack", 32'h1, {31'h0, ack});
            if (rb[0]) chk("tx_data", {24'h0, dexp}, {24'h0, q});
            wflag;
            axr(8'h04);
            chk("status2", {24'h0, s2}, rd);
            if (!rb[0]) begin
               dexp = 8'h30 + i[7:0];
               axr(8'h0c);
               chk("data", {24'h0, dexp}, rd);
            end
            axw(8'h00, 32'hc4);
         end
         i_m.stop;
      end
      // Acked data, interrupt, then release with a start request
      axw(8'h14, 32'h1);
      i_m.start;
      i_m.xfer(8'h54, q, ack);
      wflag;
      @(negedge aclk);
      chk("irq_on", 32'h1, {31'h0, irq});
      axw(8'h00, 32'hc4);
      i_m.xfer(8'ha5, q, ack);
      chk("ack", 32'h0, {31'h0, ack});
      wflag;
      axr(8'h04);
      chk("status_ack", 32'h80, rd);
      axw(8'h00, 32'h84);
      i_m.xfer(8'h5a, q, ack);
      chk("ack_off", 32'h1, {31'h0, ack});
      wflag;
      axw(8'h10, 32'hf);
      @(negedge aclk);
      chk("irq_clr", 32'h0, {31'h0, irq});
      axw(8'h00, 32'he4);
      @(negedge aclk);
      chk("start_req", 32'h1, {31'h0, start_req_q});
      i_m.stop;
      n = 0;
      while (start_req_q && n < 100) begin
         @(negedge aclk);
         n = n + 1;
      end
      chk("start_free", 32'h0, {31'h0, start_req_q});
      // Arbitration lost, then addressed: own address and general call
      axw(8'h08, 32'h55);
      for (i = 0; i < 2; i = i + 1) begin
         @(posedge aclk);
         arb_lost <= 1'b1;
         @(posedge aclk);
         arb_lost <= 1'b0;
         i_m.start;
         i_m.xfer(i ? 8'h00 : 8'h54, q, ack);
         wflag;
         axr(8'h04);
         chk("status_arb", i ? 32'h78 : 32'h68, rd);
         axw(8'h00, 32'hc4);
         i_m.stop;
      end
      // Wake from sleep on own address, interrupt masked then unmasked
      axw(8'h14, 32'h0);
      axw(8'h10, 32'hf);
      axw(8'h18, 32'h1);
      i_m.start;
      i_m.xfer(8'h54, q, ack);
      chk("wake_ack", 32'h0, {31'h0, ack});
      wflag;
      chk("wake_hold", 32'h1, {31'h0, scl_oe});
      axr(8'h18);
      chk("sleep_bit", 32'h0, rd);
      axr(8'h10);
      chk("wake_irq", 32'h2, rd & 32'h2);
      chk("irq_mask", 32'h0, {31'h0, irq});
      axw(8'h14, 32'h2);
      @(negedge aclk);
      chk("irq_unmask", 32'h1, {31'h0, irq});
      axw(8'h00, 32'hc4);
      i_m.stop;
      // Reset in mid-run
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      axr(8'h08);
      chk("rereset", 32'hfe, rd);
      end_of_test;
   end
endmodule
bind tws_target tws_target_chk i_chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
   .scl_i, .scl_o, .scl_oe, .sda_o, .sda_oe);

// ### verification/tws_bus_master.sv
// Behavioural bus controller pulling SCL and SDA low
`timescale 1ns/10ps
module tws_bus_master (
   // Pacing clock
   input  wire aclk,
   // Wired bus levels
   input  wire scl,
   input  wire sda,
   // Pull-down requests
   output reg  scl_low,
   output reg  sda_low
);
   initial begin
      scl_low = 1'b0;
      sda_low = 1'b0;
   end
   task gap(input integer n);
      repeat (n) @(negedge aclk);
   endtask
   // Release SCL and wait out any stretch
   task scl_up;
      integer n;
      begin
         scl_low = 1'b0;
         n = 0;
         #1;
         while (!scl && n < 20000) begin
            @(negedge aclk);
            n = n + 1;
         end
         gap(4);
      end
   endtask
   task start;
      begin
         gap(4);
         sda_low = 1'b1;
         gap(4);
         scl_low = 1'b1;
      end
   endtask
   // Eight bits MSB first, ninth released for acknowledge
   task xfer(input [7:0] d, output [7:0] q, output ack);
      integer i;
      begin
         for (i = 8; i >= 0; i = i - 1) begin
            gap(2);
            sda_low = (i > 0) ? !d[i-1] : 1'b0;
            gap(2);
            scl_up;
            if (i > 0)
               q[i-1] = sda;
            else
               ack = sda;
            scl_low = 1'b1;
         end
      end
   endtask
   task stop;
      begin
         gap(2);
         sda_low = 1'b1;
         gap(2);
         scl_up;
         sda_low = 1'b0;
         gap(4);
      end
   endtask
endmodule

// ### verification/tws_target_assertions.sv
// Port checks for the two-wire target
`timescale 1ns/10ps
module tws_target_chk (
   // Clock and reset
   input wire        aclk,
   input wire        aresetn,
   // Register bus
   input wire [7:0]  s_axi_awaddr,
   input wire        s_axi_awvalid,
   input wire        s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire        s_axi_wvalid,
   input wire        s_axi_wready,
   input wire        s_axi_bvalid,
   input wire        s_axi_bready,
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire        s_axi_rvalid,
   input wire        s_axi_rready,
   // Bus pins
   input wire        scl_i,
   input wire        scl_o,
   input wire        scl_oe,
   input wire        sda_o,
   input wire        sda_oe
);
   // ==========
   // Age of the last flag-clearing control write
   reg  [2:0] clr_age_q;
   wire       clr_wr;
   assign clr_wr = s_axi_awvalid && s_axi_awready && s_axi_awaddr == 8'h00
                   && s_axi_wdata[7] && !s_axi_wdata[4];
   always @(posedge aclk) begin
      if (!aresetn)
         clr_age_q <= 3'h7;
      else if (clr_wr)
         clr_age_q <= 3'h0;
      else if (clr_age_q != 3'h7)
         clr_age_q <= clr_age_q + 3'h1;
   end
   // ==========
   // Assertions
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_b_latency: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> !s_axi_bvalid ##2 s_axi_bvalid) else $error("late write response");
   a_r_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("late read response");
   a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped");
   a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data not held");
   a_bus_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready && 1'b1)
      else $error("write taken while answering");
   a_open_drain: assert property (!scl_o && !sda_o)
      else $error("pin driven high");
   a_stretch_start: assert property ($rose(scl_oe) |-> !$past(scl_i))
      else $error("stretch began with clock high");
   a_stretch_end: assert property ($fell(scl_oe) |-> clr_age_q < 3'h3)
      else $error("stretch ended without flag clear");
   a_sda_change: assert property ($changed(sda_oe) |-> !scl_i)
      else $error("data changed with clock high");
endmodule
